// file: core/dis_init_sync_alarm.sv
`timescale 1ns/1ps
`include "dis_map.svh"
module dis_init_sync_alarm (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire dis_pkg::dis_sif_req_s sif_req,
  output dis_pkg::dis_word_t sif_rdata,
  input wire logic transmit_enable_pin,
  input wire dis_pkg::dis_word_t alarm_event,
  output logic alarm_pin,
  output logic dac_output_enable,
  output dis_pkg::dis_autosync_s autosync,
  output dis_pkg::dis_sync_cfg_s sync_cfg
);
  dis_pkg::dis_state_s st;
  dis_pkg::dis_state_s next_st;
  dis_pkg::dis_word_t status;
  dis_pkg::dis_word_t mask;
  dis_pkg::dis_word_t shut_sel;
  logic clear_wr;
  logic tx_req;
  logic shut;
  logic unmasked;

  // Address match
  function automatic logic hit(input logic [6:0] addr, input logic [6:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Address inside the register file
  function automatic logic mapped(input logic [6:0] addr);
    mapped = (addr < 7'(`DIS_NREG));
  endfunction

  // Shut-off enables mapped onto alarm status positions
  function automatic dis_pkg::dis_word_t shutoff_map(input dis_pkg::dis_word_t cfg);
    shutoff_map = 16'h0000;
    shutoff_map[`DIS_ALM_DACCLK_BIT] = cfg[`DIS_SHUT_DACCLK_BIT];
    shutoff_map[`DIS_ALM_DATACLK_BIT] = cfg[`DIS_SHUT_DATACLK_BIT];
    shutoff_map[`DIS_ALM_COLL_BIT] = cfg[`DIS_SHUT_COLL_BIT];
  endfunction

  // Sticky alarm status register
  assign clear_wr = sif_req.wr && hit(sif_req.addr, `DIS_OFS_ALARM_STATUS);
  dis_alarm_sticky u_alarm (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .alarm_event(alarm_event),
    .clear_wr(clear_wr),
    .clear_data(sif_req.wdata),
    .status(status)
  );

  // Alarm and output gating terms
  assign mask = st.regs[`DIS_OFS_ALARM_MASK];
  assign shut_sel = shutoff_map(st.regs[`DIS_OFS_SHUTOFF]);
  assign unmasked = |(status & ~mask);
  assign shut = |(status & shut_sel);
  assign tx_req = transmit_enable_pin || st.regs[`DIS_OFS_TXCTRL][`DIS_TXENABLE_BIT];

  // Next-state: register writes, reads, auto-sync strobes, pins
  always_comb begin
    next_st = st;
    if (sif_req.wr && mapped(sif_req.addr) && !clear_wr) begin
      next_st.regs[sif_req.addr] = sif_req.wdata;
    end
    next_st.autosync.offset_ab = sif_req.wr && hit(sif_req.addr, `DIS_OFS_OFFSET_A);
    next_st.autosync.offset_cd = sif_req.wr && hit(sif_req.addr, `DIS_OFS_OFFSET_C);
    next_st.autosync.corr_ab = sif_req.wr && hit(sif_req.addr, `DIS_OFS_PHASE_AB);
    next_st.autosync.corr_cd = sif_req.wr && hit(sif_req.addr, `DIS_OFS_PHASE_CD);
    next_st.autosync.nco_ab = sif_req.wr && hit(sif_req.addr, `DIS_OFS_NCO_AB);
    next_st.autosync.nco_cd = sif_req.wr && hit(sif_req.addr, `DIS_OFS_NCO_CD);
    if (sif_req.rd) begin
      if (hit(sif_req.addr, `DIS_OFS_ALARM_STATUS)) begin
        next_st.rdata = status;
      end else if (mapped(sif_req.addr)) begin
        next_st.rdata = st.regs[sif_req.addr];
      end else begin
        next_st.rdata = 16'h0000;
      end
    end
    next_st.alarm_pin = unmasked;
    next_st.out_on = tx_req && !shut;
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `DIS_NREG; i++) begin
        st.regs[i] <= `DIS_REG_RST;
      end
      st.regs[`DIS_OFS_ALARM_MASK] <= `DIS_MASK_RST;
      st.rdata <= 16'h0000;
      st.autosync <= '0;
      st.alarm_pin <= 1'b0;
      st.out_on <= 1'b0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs
  assign sif_rdata = st.rdata;
  assign alarm_pin = st.alarm_pin;
  assign dac_output_enable = st.out_on;
  assign autosync = st.autosync;

  // Sync configuration fields
  assign sync_cfg.fuse_sleep = st.regs[`DIS_OFS_REF_FUSE][`DIS_FUSE_SLEEP_BIT];
  assign sync_cfg.fifoin_sel =
    st.regs[`DIS_OFS_SYNC_SRC][`DIS_FIFOIN_SEL_HI:`DIS_FIFOIN_SEL_LO];
  assign sync_cfg.fifoout_sel =
    st.regs[`DIS_OFS_SYNC_SRC][`DIS_FIFOOUT_SEL_HI:`DIS_FIFOOUT_SEL_LO];
  assign sync_cfg.fifo_input_sel =
    st.regs[`DIS_OFS_FIFO_IN_SYNC][`DIS_FIFO_INPUT_SEL_HI:`DIS_FIFO_INPUT_SEL_LO];
  assign sync_cfg.clkdiv_sync_sel = st.regs[`DIS_OFS_SYNC_SRC][`DIS_CLKDIV_SEL_BIT];
  assign sync_cfg.clkdiv_sync_ena = st.regs[`DIS_OFS_MAIN][`DIS_CLKDIV_SYNC_ENA_BIT];
  assign sync_cfg.pll_ndivsync_ena = st.regs[`DIS_OFS_PLL][`DIS_PLL_NDIVSYNC_BIT];

  property p_pin_needs_unmasked;
    @(posedge clk) disable iff (!rst_n)
    ($past(ce) && alarm_pin) |-> $past(|(status & ~mask));
  endproperty
  a_pin_needs_unmasked: assert property (p_pin_needs_unmasked)
    else $error("alarm pin raised by a masked alarm");

  property p_unmasked_raises_pin;
    @(posedge clk) disable iff (!rst_n)
    (ce && unmasked) |=> alarm_pin;
  endproperty
  a_unmasked_raises_pin: assert property (p_unmasked_raises_pin)
    else $error("unmasked alarm did not raise the alarm pin");

  property p_shutoff;
    @(posedge clk) disable iff (!rst_n)
    (ce && shut) |=> !dac_output_enable;
  endproperty
  a_shutoff: assert property (p_shutoff)
    else $error("output left on during enabled shut-off alarm");

  property p_tx_needs_enable;
    @(posedge clk) disable iff (!rst_n)
    ($past(ce) && dac_output_enable) |-> $past(tx_req && !shut);
  endproperty
  a_tx_needs_enable: assert property (p_tx_needs_enable)
    else $error("output on without transmit enable");

  property p_offset_sync;
    @(posedge clk) disable iff (!rst_n)
    (ce && sif_req.wr && (sif_req.addr == `DIS_OFS_OFFSET_A))
      |=> autosync.offset_ab && !autosync.offset_cd;
  endproperty
  a_offset_sync: assert property (p_offset_sync)
    else $error("offset A write gave no AB offset sync");

  property p_offset_cd_sync;
    @(posedge clk) disable iff (!rst_n)
    ($past(ce) && autosync.offset_cd)
      |-> $past(sif_req.wr && (sif_req.addr == `DIS_OFS_OFFSET_C));
  endproperty
  a_offset_cd_sync: assert property (p_offset_cd_sync)
    else $error("CD offset sync without offset C write");

  property p_corr_sync;
    @(posedge clk) disable iff (!rst_n)
    (ce && sif_req.wr && (sif_req.addr == `DIS_OFS_PHASE_CD))
      ##1 (ce && !(sif_req.wr && (sif_req.addr == `DIS_OFS_PHASE_CD)))
      |-> autosync.corr_cd ##1 !autosync.corr_cd;
  endproperty
  a_corr_sync: assert property (p_corr_sync)
    else $error("CD phase write sync pulse wrong");

  property p_nco_sync;
    @(posedge clk) disable iff (!rst_n)
    ($past(ce) && autosync.nco_ab)
      |-> $past(sif_req.wr && (sif_req.addr == `DIS_OFS_NCO_AB));
  endproperty
  a_nco_sync: assert property (p_nco_sync)
    else $error("AB NCO sync without phase offset write");

  // Remaining strobes, pin release, output return and status read-back
  property p_corr_ab_sync;
    @(posedge clk) disable iff (!rst_n)
    (ce && sif_req.wr && (sif_req.addr == `DIS_OFS_PHASE_AB)) |=> autosync.corr_ab;
  endproperty
  a_corr_ab_sync: assert property (p_corr_ab_sync)
    else $error("AB phase write gave no AB correction sync");

  property p_nco_cd_sync;
    @(posedge clk) disable iff (!rst_n)
    (ce && sif_req.wr && (sif_req.addr == `DIS_OFS_NCO_CD)) |=> autosync.nco_cd;
  endproperty
  a_nco_cd_sync: assert property (p_nco_cd_sync)
    else $error("CD phase offset write gave no CD NCO sync");

  property p_pin_drops;
    @(posedge clk) disable iff (!rst_n)
    (ce && !unmasked) |=> !alarm_pin;
  endproperty
  a_pin_drops: assert property (p_pin_drops)
    else $error("alarm pin held with no unmasked alarm");

  property p_out_follows_enable;
    @(posedge clk) disable iff (!rst_n)
    (ce && tx_req && !shut) |=> dac_output_enable;
  endproperty
  a_out_follows_enable: assert property (p_out_follows_enable)
    else $error("output stayed off with enable and no shut-off alarm");

  property p_status_read;
    @(posedge clk) disable iff (!rst_n)
    (ce && sif_req.rd && (sif_req.addr == `DIS_OFS_ALARM_STATUS))
      |=> (sif_rdata == $past(status));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("alarm status read-back differs from held status");

  c_shutoff: cover property (@(posedge clk) disable iff (!rst_n)
    dac_output_enable ##1 !dac_output_enable && alarm_pin);
  c_sw_enable: cover property (@(posedge clk) disable iff (!rst_n)
    !transmit_enable_pin && dac_output_enable);
  c_autosync: cover property (@(posedge clk) disable iff (!rst_n)
    autosync.corr_ab ##[1:8] autosync.corr_cd);
  c_masked_shutoff: cover property (@(posedge clk) disable iff (!rst_n)
    tx_req && !alarm_pin && !dac_output_enable);
endmodule

// file: include/dis_map.svh
`ifndef DIS_MAP_SVH
`define DIS_MAP_SVH
// Function
// - Only alarms left unmasked may drive the alarm pin.
// - An unmasked alarm raises the alarm pin; enabled shut-off disables outputs.
// - Transmission starts only on transmit-enable pin high or software enable bit.
// - Writing channel A or C offset auto-syncs the AB or CD offset block.
// - Writing AB or CD correction phase auto-syncs that pair's correction block.
// - Writing AB or CD NCO phase offset auto-syncs that pair's NCO mixer.
// - A set alarm bit stays set until the host clears it.
// - Enabled clock-loss or collision alarms shut outputs off regardless of enable.

// Register file size and offsets
`define DIS_NREG 33
`define DIS_OFS_MAIN 7'h00
`define DIS_OFS_SHUTOFF 7'h02
`define DIS_OFS_TXCTRL 7'h03
`define DIS_OFS_ALARM_STATUS 7'h05
`define DIS_OFS_ALARM_MASK 7'h07
`define DIS_OFS_OFFSET_A 7'h08
`define DIS_OFS_OFFSET_C 7'h0A
`define DIS_OFS_PHASE_AB 7'h10
`define DIS_OFS_PHASE_CD 7'h11
`define DIS_OFS_NCO_AB 7'h12
`define DIS_OFS_NCO_CD 7'h13
`define DIS_OFS_PLL 7'h18
`define DIS_OFS_REF_FUSE 7'h1B
`define DIS_OFS_FIFO_IN_SYNC 7'h1F
`define DIS_OFS_SYNC_SRC 7'h20

// Field positions
`define DIS_CLKDIV_SYNC_ENA_BIT 2
`define DIS_PLL_NDIVSYNC_BIT 11
`define DIS_FUSE_SLEEP_BIT 11
`define DIS_FIFOIN_SEL_HI 15
`define DIS_FIFOIN_SEL_LO 12
`define DIS_FIFOOUT_SEL_HI 11
`define DIS_FIFOOUT_SEL_LO 8
`define DIS_FIFO_INPUT_SEL_HI 3
`define DIS_FIFO_INPUT_SEL_LO 2
`define DIS_CLKDIV_SEL_BIT 0
`define DIS_TXENABLE_BIT 0
`define DIS_SHUT_DACCLK_BIT 14
`define DIS_SHUT_DATACLK_BIT 13
`define DIS_SHUT_COLL_BIT 12
`define DIS_ALM_COLL_BIT 13
`define DIS_ALM_DACCLK_BIT 10
`define DIS_ALM_DATACLK_BIT 9

// Reset values
`define DIS_REG_RST 16'h0000
`define DIS_MASK_RST 16'hFFFF
`define DIS_STATUS_RST 16'h0000
`endif

// file: include/dis_pkg.sv
`include "dis_map.svh"
package dis_pkg;
  typedef logic [15:0] dis_word_t;

  // Decoded serial-interface access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    dis_word_t wdata;
  } dis_sif_req_s;

  // One-cycle auto-sync strobes to datapath blocks
  typedef struct packed {
    logic offset_ab;
    logic offset_cd;
    logic corr_ab;
    logic corr_cd;
    logic nco_ab;
    logic nco_cd;
  } dis_autosync_s;

  // Sync configuration seen by FIFO, divider and PLL
  typedef struct packed {
    logic fuse_sleep;
    logic [3:0] fifoin_sel;
    logic [3:0] fifoout_sel;
    logic [1:0] fifo_input_sel;
    logic clkdiv_sync_sel;
    logic clkdiv_sync_ena;
    logic pll_ndivsync_ena;
  } dis_sync_cfg_s;

  typedef struct packed {
    dis_word_t [`DIS_NREG-1:0] regs;
    dis_word_t rdata;
    dis_autosync_s autosync;
    logic alarm_pin;
    logic out_on;
  } dis_state_s;

  typedef struct packed {
    dis_word_t status;
  } dis_alarm_state_s;
endpackage

// file: core/dis_alarm_sticky.sv
`timescale 1ns/1ps
`include "dis_map.svh"
module dis_alarm_sticky (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire dis_pkg::dis_word_t alarm_event,
  input wire logic clear_wr,
  input wire dis_pkg::dis_word_t clear_data,
  output dis_pkg::dis_word_t status
);
  dis_pkg::dis_alarm_state_s st;
  dis_pkg::dis_alarm_state_s next_st;

  // Zeros written clear bits; a new event wins over its clear
  always_comb begin
    next_st = st;
    if (clear_wr) begin
      next_st.status = st.status & clear_data;
    end
    next_st.status = next_st.status | alarm_event;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.status <= `DIS_STATUS_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign status = st.status;

  property p_sticky_hold;
    @(posedge clk) disable iff (!rst_n)
    (ce && !clear_wr) |=> ((status & $past(status)) == $past(status));
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("alarm bit dropped without a clear");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
    (ce && clear_wr && (alarm_event != 16'h0000))
      |=> ((status & $past(alarm_event)) == $past(alarm_event));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("alarm event lost during clear");
endmodule

// file: dv/dis_host_model.sv
`timescale 1ns/1ps
// Host controller side: serial accesses and the transmit enable pin
module dis_host_model (
  input wire logic clk,
  input wire dis_pkg::dis_word_t sif_rdata,
  output dis_pkg::dis_sif_req_s sif_req,
  output logic transmit_enable_pin
);
  // Idle bus, transmit disabled from power-up
  initial begin
    sif_req = '0;
    transmit_enable_pin = 1'b0;
  end

  // One write, done before the caller moves on
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk);
    sif_req.wr = 1'b1;
    sif_req.addr = a;
    sif_req.wdata = d;
    @(negedge clk);
    sif_req.wr = 1'b0;
    sif_req.addr = ~a; // Released lines do not keep the old value
    sif_req.wdata = ~d;
  endtask

  // One read; data sampled after the taking edge
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge clk);
    sif_req.rd = 1'b1;
    sif_req.addr = a;
    @(negedge clk);
    sif_req.rd = 1'b0;
    sif_req.addr = ~a;
    d = sif_rdata;
  endtask

  // Transmit enable pin level
  task automatic set_txen(input logic v);
    @(negedge clk);
    transmit_enable_pin = v;
  endtask
endmodule

// file: dv/dis_init_sync_alarm_test.sv
`timescale 1ns/1ps
module dis_init_sync_alarm_test;
  logic clk;
  logic rst_n;
  logic ce;
  dis_pkg::dis_word_t alarm_event;
  dis_pkg::dis_sif_req_s sif_req;
  dis_pkg::dis_word_t sif_rdata;
  logic transmit_enable_pin;
  logic alarm_pin;
  logic dac_output_enable;
  dis_pkg::dis_autosync_s autosync;
  dis_pkg::dis_sync_cfg_s sync_cfg;
  int fail_count;
  int checks;
  logic [15:0] rv;
  logic [6:0] as_addr [6] = '{7'h08, 7'h0A, 7'h10, 7'h11, 7'h12, 7'h13};

  dis_init_sync_alarm dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sif_req(sif_req), .sif_rdata(sif_rdata),
    .transmit_enable_pin(transmit_enable_pin), .alarm_event(alarm_event),
    .alarm_pin(alarm_pin), .dac_output_enable(dac_output_enable),
    .autosync(autosync), .sync_cfg(sync_cfg)
  );

  dis_host_model host (
    .clk(clk), .sif_rdata(sif_rdata), .sif_req(sif_req),
    .transmit_enable_pin(transmit_enable_pin)
  );

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic test_done;
    $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    fail_count = 0;
    checks = 0;
    alarm_event = '0;
    ce = 1'b1;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    host.rd(7'h07, rv);
    chk(rv, 16'hFFFF);
    host.rd(7'h00, rv);
    chk(rv, 16'h0000);
    chk({15'h0000, dac_output_enable}, 16'h0000);
    $display("Test reset done");
    // Start-up configuration of sync sources and enables
    host.wr(7'h1B, 16'h0800);
    host.wr(7'h20, 16'h2401);
    host.wr(7'h1F, 16'h000C);
    host.wr(7'h00, 16'h0004);
    host.wr(7'h18, 16'h0800);
    chk(16'(sync_cfg), {2'b00, 1'b1, 4'h2, 4'h4, 2'h3, 3'b111});
    // Idle window: outputs stay off while transmit is still disabled
    tick(4);
    chk({15'h0000, dac_output_enable}, 16'h0000);
    host.wr(7'h00, 16'h0000);
    host.wr(7'h18, 16'h0000);
    host.wr(7'h20, 16'h0000);
    chk(16'(sync_cfg), {2'b00, 1'b1, 4'h0, 4'h0, 2'h3, 3'b000});
    host.rd(7'h18, rv);
    chk(rv, 16'h0000);
    $display("Test sync config done");
    // Auto-sync strobes, one per register, one cycle long
    for (int i = 0; i < 6; i++) begin
      host.wr(as_addr[i], 16'h1234 + 16'(i));
      chk(16'(autosync), 16'h0020 >> i);
      tick(1);
      chk(16'(autosync), 16'h0000);
    end
    host.wr(7'h21, 16'hBEEF);
    chk(16'(autosync), 16'h0000);
    host.rd(7'h21, rv);
    chk(rv, 16'h0000);
    $display("Test auto-sync done");
    // Masked alarm is recorded but keeps the pin low
    host.wr(7'h05, 16'h0000);
    alarm_event = 16'h2000;
    tick(1);
    alarm_event = '0;
    tick(2);
    chk({15'h0000, alarm_pin}, 16'h0000);
    host.rd(7'h05, rv);
    chk(rv, 16'h2000);
    host.wr(7'h05, 16'h0000);
    host.rd(7'h05, rv);
    chk(rv, 16'h0000);
    // Unmasked collision alarm with shut-off enabled
    host.wr(7'h07, 16'hDFFF);
    host.wr(7'h02, 16'h1000);
    host.set_txen(1'b1);
    tick(1);
    chk({15'h0000, dac_output_enable}, 16'h0001);
    alarm_event = 16'h2000;
    tick(1);
    alarm_event = '0;
    tick(2);
    chk({14'h0000, alarm_pin, dac_output_enable}, 16'h0002);
    tick(3);
    chk({14'h0000, alarm_pin, dac_output_enable}, 16'h0002);
    host.rd(7'h05, rv);
    chk(rv, 16'h2000);
    host.wr(7'h05, 16'h0000);
    tick(1);
    chk({14'h0000, alarm_pin, dac_output_enable}, 16'h0001);
    $display("Test alarm done");
    // Software transmit enable instead of the pin
    host.set_txen(1'b0);
    tick(1);
    chk({15'h0000, dac_output_enable}, 16'h0000);
    host.wr(7'h03, 16'h0001);
    tick(1);
    chk({15'h0000, dac_output_enable}, 16'h0001);
    // Clock enable low: the disabling write is not taken
    ce = 1'b0;
    host.wr(7'h03, 16'h0000);
    ce = 1'b1;
    tick(1);
    chk({15'h0000, dac_output_enable}, 16'h0001);
    $display("Test software enable done");
    // Clock-loss alarms shut off the software-enabled output, pin stays masked
    host.wr(7'h02, 16'h6000);
    alarm_event = 16'h0600;
    tick(1);
    alarm_event = '0;
    tick(2);
    chk({14'h0000, alarm_pin, dac_output_enable}, 16'h0000);
    host.wr(7'h05, 16'hFBFF);
    tick(1);
    chk({14'h0000, alarm_pin, dac_output_enable}, 16'h0000);
    host.rd(7'h05, rv);
    chk(rv, 16'h0200);
    // A new event in the same cycle as its clear stays set
    fork
      host.wr(7'h05, 16'h0000);
      begin
        @(negedge clk);
        alarm_event = 16'h0400;
        @(negedge clk);
        alarm_event = '0;
      end
    join
    host.rd(7'h05, rv);
    chk(rv, 16'h0400);
    host.wr(7'h05, 16'h0000);
    tick(1);
    chk({14'h0000, alarm_pin, dac_output_enable}, 16'h0001);
    // Dual-sync mode: divider sync stays enabled during transmission
    host.wr(7'h00, 16'h0004);
    tick(2);
    chk({14'h0000, sync_cfg.clkdiv_sync_ena, dac_output_enable}, 16'h0003);
    $display("Test shut-off done");
    test_done();
  end
endmodule
